/* File: hdl/cxseq_top.v */
// Exception sequencer: ranks exception sources, reads vectors,
// pushes status word and return PC, loads PC and SP.
// Assumes a Wishbone classic master, a CPU on clk_i and a memory
// bus that holds mem_req_o until mem_ack_i.
//
// What this block does
// - Simultaneous exceptions served one by one by rank
// - Reset outranks every other exception
// - Init pin rise with NMI high: power-on
// - Init pin rise with NMI low: manual
// - Manual reset waits for bus cycle end
// - Errors, interrupts wait for executing instruction
// - Trap instruction starts trap handling
// - Undefined code outside slot: general illegal
// - Undefined or PC write in slot: slot illegal
// - Power-on reads PC at 0, SP at 4
// - Manual reset reads PC at 8, SP at 12
// - Reset clears vector base, mask to ones
// - After reset, execute from loaded PC
// - Other exceptions push to stack register
// - Push status first, then return PC
// - Interrupt writes its level into mask
// - Errors and instructions keep the mask
// - Fetch handler address, continue there
// - Fixed vector numbers per source
// - Trap operand maps onto vectors 32-63
// - Reserved vectors go to no source
// - Reset entry is vector times four
// - Others: vector base plus vector times four
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cxseq_regs.vh"

module cxseq_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  // Pins
  input  wire        chip_init_pin_n_i,
  input  wire        nmi_pin_i,
  // Instruction decoder
  input  wire        dec_valid_i,
  input  wire        dec_slot_i,
  input  wire        dec_undef_i,
  input  wire        dec_pcwr_i,
  input  wire        software_trap_insn_i,
  input  wire [7:0]  trap_imm_i,
  input  wire        insn_done_i,
  input  wire [31:0] next_pc_i,
  input  wire [31:0] stack_gpr_i,
  // Address errors and interrupt controller
  input  wire        cpu_aerr_i,
  input  wire        dma_aerr_i,
  input  wire        irq_req_i,
  input  wire [7:0]  irq_vec_i,
  input  wire [3:0]  irq_lvl_i,
  output wire        irq_ack_o,
  // Memory bus
  input  wire        mem_busy_i,
  output wire        mem_req_o,
  output reg         mem_we_o,
  output reg  [31:0] mem_adr_o,
  output reg  [31:0] mem_dat_o,
  input  wire [31:0] mem_dat_i,
  input  wire        mem_ack_i,
  // CPU control
  output wire        cpu_hold_o,
  output reg         pc_load_o,
  output reg  [31:0] pc_o,
  output reg         sp_load_o,
  output reg  [31:0] sp_o,
  output reg  [31:0] status_word_o,
  output reg  [31:0] vector_base_reg_o
);

////////////////////////////////////////////////////////////////////
// States and kinds

localparam [7:0] S_IDLE = 8'h01;
localparam [7:0] S_HOLD = 8'h02;
localparam [7:0] S_RPC  = 8'h04;
localparam [7:0] S_RSP  = 8'h08;
localparam [7:0] S_WAIT = 8'h10;
localparam [7:0] S_PSR  = 8'h20;
localparam [7:0] S_PPC  = 8'h40;
localparam [7:0] S_VEC  = 8'h80;

reg  [7:0]  state;
reg  [7:0]  vec;
reg         is_irq;
reg  [3:0]  lvl;
reg  [31:0] ret_pc;
reg  [31:0] sp_base;
reg         man_pend;
reg         cae_pend;
reg         dae_pend;

////////////////////////////////////////////////////////////////////
// Pin synchronisers and init pin rise detect

reg  [1:0]  init_sync;
reg  [1:0]  nmi_sync;
reg         init_prev;

always @(posedge clk_i) begin
  init_sync <= {init_sync[0], chip_init_pin_n_i};
  nmi_sync  <= {nmi_sync[0], nmi_pin_i};
  init_prev <= init_sync[1];
end

// The rise detector follows the synchronised pin through reset, so a
// pin held high across reset gives no false rise afterwards.
wire init_low  = ~init_sync[1];
wire init_rise = init_sync[1] & ~init_prev;
wire man_go    = (init_rise | man_pend) & ~mem_busy_i;

////////////////////////////////////////////////////////////////////
// Source ranking

wire bus_st   = |(state & (S_RPC | S_RSP | S_PSR | S_PPC | S_VEC));
wire cae      = cpu_aerr_i | cae_pend;
wire dae      = dma_aerr_i | dae_pend;
// Reserved interrupt vectors are never taken; such a request just waits
wire irq_ok   = irq_req_i &
                ((irq_vec_i == `CXS_VEC_NMI) |
                 (irq_vec_i == `CXS_VEC_UBRK) |
                 (irq_vec_i >= `CXS_VEC_EXTERNAL_REQUEST_LINE0));
wire slot_bad = dec_slot_i & (dec_undef_i | dec_pcwr_i);
wire ill      = ~dec_slot_i & dec_undef_i;
wire trap     = software_trap_insn_i & ~dec_slot_i;
wire async_ev = dec_valid_i & (cae | dae | irq_ok);
wire insn_ev  = dec_valid_i & (slot_bad | ill | trap);

reg [7:0] pick_vec;
always @* begin
  if (cae)
    pick_vec = `CXS_VEC_CAE;
  else if (dae)
    pick_vec = `CXS_VEC_DAE;
  else if (irq_ok)
    pick_vec = irq_vec_i;
  else if (slot_bad)
    pick_vec = `CXS_VEC_SLOT;
  else if (ill)
    pick_vec = `CXS_VEC_ILL;
  else
    pick_vec = {`CXS_TRAP_HI, trap_imm_i[4:0]};
end

wire take_irq = state[0] & async_ev & ~cae & ~dae & irq_ok;
assign irq_ack_o = take_irq;

////////////////////////////////////////////////////////////////////
// Vector entry address

// Reset entries are absolute; all others are offset by the vector base
wire [31:0] vec_off  = {22'h000000, vec, 2'b00};
wire [31:0] rst_adr  = vec_off;
wire [31:0] exc_adr  = vector_base_reg_o + vec_off;

assign mem_req_o  = bus_st;
assign cpu_hold_o = ~state[0];

////////////////////////////////////////////////////////////////////
// Wishbone decode, read by the sequencer and the slave below
// A write lands on the edge that sees the strobe without ack, so it
// takes effect once although the strobe stands for two edges.

reg         wb_ack;
reg  [31:0] wb_dat;
wire        wb_wr = cyc_i & stb_i & we_i & ~wb_ack;
wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}};

////////////////////////////////////////////////////////////////////
// Sequencer

always @(posedge clk_i) begin
  pc_load_o <= 1'b0;
  sp_load_o <= 1'b0;
  if (rst_i) begin
    state             <= S_HOLD;
    vec               <= `CXS_VEC_POR;
    is_irq            <= 1'b0;
    lvl               <= 4'h0;
    ret_pc            <= 32'h00000000;
    sp_base           <= 32'h00000000;
    man_pend          <= 1'b0;
    cae_pend          <= 1'b0;
    dae_pend          <= 1'b0;
    mem_we_o          <= 1'b0;
    mem_adr_o         <= 32'h00000000;
    mem_dat_o         <= 32'h00000000;
    pc_o              <= 32'h00000000;
    sp_o              <= 32'h00000000;
    status_word_o     <= `CXS_SR_RST;
    vector_base_reg_o <= `CXS_VBR_RST;
  end else if (init_low) begin
    state    <= S_HOLD;
    man_pend <= 1'b0;
    cae_pend <= 1'b0;
    dae_pend <= 1'b0;
  end else if (man_pend | (init_rise & ~nmi_sync[1])) begin
    man_pend <= ~man_go;
    if (man_go) begin
      state     <= S_RPC;
      vec       <= `CXS_VEC_MAN;
      mem_we_o  <= 1'b0;
      mem_adr_o <= {22'h000000, `CXS_VEC_MAN, 2'b00};
    end
  end else if (init_rise) begin
    state     <= S_RPC;
    vec       <= `CXS_VEC_POR;
    mem_we_o  <= 1'b0;
    mem_adr_o <= {22'h000000, `CXS_VEC_POR, 2'b00};
  end else begin
    // Set wins over clear for the address error latches
    cae_pend <= cpu_aerr_i | (cae_pend & ~(state[0] & async_ev));
    dae_pend <= dma_aerr_i |
                (dae_pend & ~(state[0] & async_ev & ~cae));
    case (state)
      S_HOLD: begin
        // Left only through a rise of the init pin
        state <= S_HOLD;
      end
      S_IDLE: begin
        if (async_ev) begin
          vec    <= pick_vec;
          is_irq <= ~cae & ~dae;
          lvl    <= irq_lvl_i;
          state  <= S_WAIT;
        end else if (insn_ev) begin
          vec     <= pick_vec;
          is_irq  <= 1'b0;
          ret_pc  <= next_pc_i;
          sp_base <= stack_gpr_i;
          state   <= S_PSR;
          mem_we_o  <= 1'b1;
          mem_adr_o <= stack_gpr_i - `CXS_LWORD;
          mem_dat_o <= status_word_o;
        end
      end
      S_WAIT: begin
        // Async sources let the instruction in flight finish first
        if (insn_done_i) begin
          ret_pc    <= next_pc_i;
          sp_base   <= stack_gpr_i;
          state     <= S_PSR;
          mem_we_o  <= 1'b1;
          mem_adr_o <= stack_gpr_i - `CXS_LWORD;
          mem_dat_o <= status_word_o;
        end
      end
      S_RPC: begin
        if (mem_ack_i) begin
          pc_o      <= mem_dat_i;
          state     <= S_RSP;
          mem_adr_o <= rst_adr + `CXS_LWORD;
        end
      end
      S_RSP: begin
        if (mem_ack_i) begin
          sp_o      <= mem_dat_i;
          vector_base_reg_o <= `CXS_VBR_RST;
          status_word_o[`CXS_SR_MHI:`CXS_SR_MLO] <= `CXS_MASK_ALL;
          pc_load_o <= 1'b1;
          sp_load_o <= 1'b1;
          state     <= S_IDLE;
        end
      end
      S_PSR: begin
        if (mem_ack_i) begin
          mem_adr_o <= sp_base - `CXS_LWORD2;
          mem_dat_o <= ret_pc;
          state     <= S_PPC;
        end
      end
      S_PPC: begin
        // Mask changes only once both pushes are accepted
        if (mem_ack_i) begin
          mem_we_o  <= 1'b0;
          mem_adr_o <= exc_adr;
          state     <= S_VEC;
          if (is_irq)
            status_word_o[`CXS_SR_MHI:`CXS_SR_MLO] <= lvl;
        end
      end
      S_VEC: begin
        if (mem_ack_i) begin
          pc_o      <= mem_dat_i;
          sp_o      <= sp_base - `CXS_LWORD2;
          pc_load_o <= 1'b1;
          sp_load_o <= 1'b1;
          state     <= S_IDLE;
        end
      end
      default: begin
        state <= S_HOLD;
      end
    endcase
    // Software writes take effect only in S_IDLE and are dropped in every other state
    if (wb_wr & state[0]) begin
      if (adr_i == `CXS_OFF_VBR)
        vector_base_reg_o <= (vector_base_reg_o & ~wmask) | (dat_i & wmask);
      if (adr_i == `CXS_OFF_SR)
        status_word_o <= (status_word_o & ~wmask) | (dat_i & wmask);
    end
  end
end

////////////////////////////////////////////////////////////////////
// Wishbone slave, answers one cycle after the strobe

// Unmapped offsets read zero and are still acked

always @(posedge clk_i) begin
  if (rst_i) begin
    wb_ack <= 1'b0;
    wb_dat <= 32'h00000000;
  end else begin
    wb_ack <= cyc_i & stb_i & ~wb_ack;
    case (adr_i)
      `CXS_OFF_VBR:  wb_dat <= vector_base_reg_o;
      `CXS_OFF_SR:   wb_dat <= status_word_o;
      `CXS_OFF_STAT: wb_dat <= {23'h000000, man_pend, state};
      `CXS_OFF_LVEC: wb_dat <= {24'h000000, vec};
      default:       wb_dat <= 32'h00000000;
    endcase
  end
end

assign ack_o = wb_ack;
assign dat_o = wb_dat;

endmodule // cxseq_top

/* File: inc/cxseq_regs.vh */
// Constants of the exception sequencer: register map, vectors, fields.
// Assumes inclusion by hdl/cxseq_top.v only.
`ifndef CXSEQ_REGS_VH
`define CXSEQ_REGS_VH

// Wishbone register byte offsets
`define CXS_OFF_VBR    8'h00
`define CXS_OFF_SR     8'h04
`define CXS_OFF_STAT   8'h08
`define CXS_OFF_LVEC   8'h0C

// Reset values
`define CXS_VBR_RST    32'h00000000
`define CXS_SR_RST     32'h000000F0
`define CXS_MASK_ALL   4'hF

// Interrupt mask field of the status word
`define CXS_SR_MHI     7
`define CXS_SR_MLO     4

// Vector numbers
`define CXS_VEC_POR    8'h00
`define CXS_VEC_MAN    8'h02
`define CXS_VEC_ILL    8'h04
`define CXS_VEC_SLOT   8'h06
`define CXS_VEC_CAE    8'h09
`define CXS_VEC_DAE    8'h0A
`define CXS_VEC_NMI    8'h0B
`define CXS_VEC_UBRK   8'h0C
`define CXS_VEC_EXTERNAL_REQUEST_LINE0   8'h40
`define CXS_TRAP_HI    3'h1

// Address steps of one and two longwords
`define CXS_LWORD      32'h00000004
`define CXS_LWORD2     32'h00000008

`endif

/* File: test/cxseq_assertions.sv */
// Port assertions of the exception sequencer.
// Bound into cxseq_top; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module cxseq_assertions (
  // Clock and reset
  input logic        clk_i,
  input logic        rst_i,
  // Inputs
  input logic [31:0] next_pc_i,
  input logic [31:0] stack_gpr_i,
  input logic [7:0]  irq_vec_i,
  input logic [3:0]  irq_lvl_i,
  input logic        mem_busy_i,
  input logic [31:0] mem_dat_i,
  input logic        mem_ack_i,
  // Outputs
  input logic        irq_ack_o,
  input logic        cpu_hold_o,
  input logic        mem_req_o,
  input logic        mem_we_o,
  input logic [31:0] mem_adr_o,
  input logic [31:0] mem_dat_o,
  input logic        sp_load_o,
  input logic [31:0] sp_o,
  input logic [31:0] status_word_o,
  input logic [31:0] vector_base_reg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       irq_seen = 1'b0;
  logic [3:0] lvl_q    = 4'h0;
  wire        pc_ack   = mem_req_o && mem_we_o && mem_ack_i && mem_adr_o == stack_gpr_i - 32'h8;
  // Level of the accepted interrupt, kept until the handler is loaded
  always @(posedge clk_i) begin
    if (rst_i || sp_load_o) begin
      irq_seen <= 1'b0;
    end else if (irq_ack_o) begin
      irq_seen <= 1'b1;
      lvl_q    <= irq_lvl_i;
    end
  end
  ////////////////////////////////////////
  sequence s_sr_push;
    mem_req_o && mem_we_o && mem_ack_i && mem_adr_o == stack_gpr_i - 32'h4;
  endsequence
  sequence s_pc_push;
    pc_ack;
  endsequence
  property p_rst_state;
    $past(rst_i) |-> !mem_req_o && status_word_o[7:4] == 4'hF && vector_base_reg_o == 32'h0;
  endproperty
  property p_man_defer;
    $rose(mem_req_o) && !mem_we_o && mem_adr_o == 32'h8 |-> !$past(mem_busy_i);
  endproperty
  property p_rst_load;
    mem_req_o && mem_ack_i && !mem_we_o && (mem_adr_o == 32'h4 || mem_adr_o == 32'hC)
      |=> sp_load_o && sp_o == $past(mem_dat_i) && status_word_o[7:4] == 4'hF &&
          vector_base_reg_o == 32'h0;
  endproperty
  property p_sr_push;
    $rose(mem_req_o) && mem_we_o |-> mem_adr_o == stack_gpr_i - 32'h4 && mem_dat_o == status_word_o;
  endproperty
  property p_pc_push;
    s_sr_push |=> mem_we_o && mem_adr_o == stack_gpr_i - 32'h8 && mem_dat_o == next_pc_i;
  endproperty
  property p_mask_irq;
    s_pc_push ##0 irq_seen |=> status_word_o[7:4] == lvl_q;
  endproperty
  property p_mask_keep;
    s_pc_push ##0 !irq_seen |=> $stable(status_word_o);
  endproperty
  property p_irq_vec;
    irq_ack_o |-> irq_vec_i == 8'h0B || irq_vec_i == 8'h0C || irq_vec_i >= 8'h40;
  endproperty
  property p_hold;
    mem_req_o |-> cpu_hold_o;
  endproperty
  property p_run;
    sp_load_o |-> !cpu_hold_o;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state");
  a_man_defer: assert property (p_man_defer) else $error("busy ignored");
  a_rst_load: assert property (p_rst_load) else $error("reset load");
  a_sr_push: assert property (p_sr_push) else $error("status push");
  a_pc_push: assert property (p_pc_push) else $error("pc push");
  a_mask_irq: assert property (p_mask_irq) else $error("mask not set");
  a_mask_keep: assert property (p_mask_keep) else $error("mask changed");
  a_irq_vec: assert property (p_irq_vec) else $error("reserved vector");
  a_hold: assert property (p_hold) else $error("cpu not held");
  a_run: assert property (p_run) else $error("cpu not released");
endmodule // cxseq_assertions

bind cxseq_top cxseq_assertions cxseq_assertions_i (.*);

/* File: test/cxseq_bench.sv */
// Self-checking bench of the exception sequencer.
// Memory side answered by cxseq_mem_model.
`timescale 1ns/1ps
module cxseq_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00, trap_imm_i = 8'h00, irq_vec_i = 8'h00;
  logic [3:0]  sel_i = 4'hF, irq_lvl_i = 4'h0;
  logic [31:0] dat_i = 32'h0, next_pc_i = 32'h0, stack_gpr_i = 32'h0, vector_base_reg, sr_m;
  logic        chip_init_pin_n_i = 1'b1, nmi_pin_i = 1'b1, dec_valid_i = 1'b0;
  logic        dec_slot_i = 1'b0, dec_undef_i = 1'b0, dec_pcwr_i = 1'b0, slow = 1'b0;
  logic        software_trap_insn_i = 1'b0, insn_done_i = 1'b0, cpu_aerr_i = 1'b0;
  logic        dma_aerr_i = 1'b0, irq_req_i = 1'b0, mem_busy_i = 1'b0;
  logic [31:0] dat_o, mem_adr_o, mem_dat_o, mem_dat_i, pc_o, sp_o, status_word_o;
  logic [31:0] vector_base_reg_o;
  logic        ack_o, irq_ack_o, mem_req_o, mem_we_o, mem_ack_i, cpu_hold_o;
  logic        pc_load_o, sp_load_o;
  logic [65:0] exp_q[$];
  int          n_errors = 0, n_checks = 0;
  cxseq_top cxseq_top_i (.*);
  cxseq_mem_model cxseq_mem_model_i (.clk_i(clk_i), .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_adr_i(mem_adr_o), .mem_ack_o(mem_ack_i), .mem_dat_o(mem_dat_i));
  initial forever #5 clk_i = ~clk_i;
  ////////////////////////////////////////
  task automatic want(input logic [1:0] k, input logic [31:0] a, input logic [31:0] d);
    exp_q.push_back({k, a, d});
  endtask
  task automatic note(input logic [1:0] k, input logic [31:0] a, input logic [31:0] d);
    logic [65:0] e;
    e = exp_q.size() > 0 ? exp_q.pop_front() : {66{1'bx}};
    n_checks++;
    if (e !== {k, a, d}) begin
      n_errors++;
      $display("wrong value at %0t got %h expected %h", $time, {k, a, d}, e);
    end
  endtask
  always @(posedge clk_i) begin
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1)
      note({1'b0, mem_we_o}, mem_adr_o, mem_we_o ? mem_dat_o : 32'h0);
    if (pc_load_o === 1'b1) note(2'd2, pc_o, sp_o);
    if (ack_o === 1'b1 && !we_i) note(2'd3, 32'h0, dat_o);
    if (irq_ack_o === 1'b1) irq_req_i <= 1'b0;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic boot(input logic nmi, input logic busy);
    chip_init_pin_n_i <= 1'b0;
    nmi_pin_i <= nmi;
    mem_busy_i <= busy;
    repeat (6) @(posedge clk_i);
    chip_init_pin_n_i <= 1'b1;
    if (busy) repeat (10) @(posedge clk_i);
    mem_busy_i <= 1'b0;
    do @(posedge clk_i); while (pc_load_o !== 1'b1);
    @(posedge clk_i);
    $display("reset test done nmi %0d", nmi);
  endtask
  task automatic exc(input logic [3:0] f, input logic [7:0] v);
    logic [31:0] va;
    va = vector_base_reg + {22'h0, v, 2'b00};
    want(2'd1, stack_gpr_i - 32'h4, sr_m);
    want(2'd1, stack_gpr_i - 32'h8, next_pc_i);
    want(2'd0, va, 32'h0);
    want(2'd2, ~va, stack_gpr_i - 32'h8);
    slow <= 1'($urandom);
    {software_trap_insn_i, dec_pcwr_i, dec_undef_i, dec_slot_i} <= f;
    dec_valid_i <= 1'b1;
    @(posedge clk_i);
    {software_trap_insn_i, dec_pcwr_i, dec_undef_i, dec_slot_i} <= 4'h0;
    dec_valid_i <= 1'b0;
    insn_done_i <= 1'b1;
    @(posedge clk_i);
    insn_done_i <= 1'b0;
    do @(posedge clk_i); while (cpu_hold_o !== 1'b0);
    $display("exception test done vector %0d", v);
  endtask
  task automatic print_verdict;
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h02738656));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    want(2'd3, 32'h0, 32'hF0);
    wb(1'b0, 8'h04, 32'h0);
    want(2'd0, 32'h0, 32'h0);
    want(2'd0, 32'h4, 32'h0);
    want(2'd2, ~32'h0, ~32'h4);
    boot(1'b1, 1'b0);
    vector_base_reg = $urandom & 32'hFFFFFFFC;
    wb(1'b1, 8'h00, vector_base_reg);
    want(2'd0, 32'h8, 32'h0);
    want(2'd0, 32'hC, 32'h0);
    want(2'd2, ~32'h8, ~32'hC);
    boot(1'b0, 1'b1);
    sr_m = {24'h0, 4'($urandom), 4'h0};
    wb(1'b1, 8'h00, vector_base_reg);
    wb(1'b1, 8'h04, sr_m);
    want(2'd3, 32'h0, vector_base_reg);
    wb(1'b0, 8'h00, 32'h0);
    want(2'd3, 32'h0, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    stack_gpr_i <= $urandom & 32'hFFFFFFFC;
    next_pc_i <= $urandom & 32'hFFFFFFFE;
    trap_imm_i <= 8'($urandom);
    irq_req_i <= 1'b1;
    irq_vec_i <= 8'd13 + 8'($urandom % 19);
    irq_lvl_i <= 4'($urandom);
    @(posedge clk_i);
    exc(4'b1000, 8'd32 + {3'b0, trap_imm_i[4:0]});
    irq_vec_i <= 8'd64 + 8'($urandom % 192);
    cpu_aerr_i <= 1'b1;
    dma_aerr_i <= 1'b1;
    @(posedge clk_i);
    cpu_aerr_i <= 1'b0;
    dma_aerr_i <= 1'b0;
    exc(4'b0011, 8'd9);
    exc(4'b0011, 8'd10);
    exc(4'b0011, irq_vec_i);
    sr_m[7:4] = irq_lvl_i;
    exc(4'b0011, 8'd6);
    exc(4'b0101, 8'd6);
    exc(4'b0010, 8'd4);
    want(2'd3, 32'h0, sr_m);
    wb(1'b0, 8'h04, 32'h0);
    want(2'd3, 32'h0, 32'h4);
    wb(1'b0, 8'h0C, 32'h0);
    want(2'd3, 32'h0, 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    sel_i <= 4'h2;
    wb(1'b1, 8'h00, 32'hFFFFFFFF);
    sel_i <= 4'hF;
    want(2'd3, 32'h0, vector_base_reg | 32'h0000FF00);
    wb(1'b0, 8'h00, 32'h0);
    print_verdict;
  end
endmodule // cxseq_bench

/* File: test/cxseq_mem_model.sv */
// Memory partner: reads return the inverted address, slow_i adds waits.
// Assumes the sequencer holds its request until the ack.
`timescale 1ns/1ps
module cxseq_mem_model (
  // Clock and mode
  input  logic        clk_i,
  input  logic        slow_i,
  // Memory bus
  input  logic        mem_req_i,
  input  logic [31:0] mem_adr_i,
  output logic        mem_ack_o = 1'b0,
  output logic [31:0] mem_dat_o = 32'h0
);
  logic [1:0] wait_q = 2'h0;
  // Data toggles when not acked so stale values never match
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    mem_dat_o <= ~mem_dat_o;
    if (!mem_req_i || mem_ack_o) begin
      wait_q <= slow_i ? 2'h3 : 2'h0;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else begin
      mem_ack_o <= 1'b1;
      mem_dat_o <= ~mem_adr_i;
    end
  end
endmodule // cxseq_mem_model
